// ==== vram_host_regs.vh ====
`ifndef VRAM_HOST_REGS_VH
`define VRAM_HOST_REGS_VH
// ==========================================================
// Register map, byte offsets on the AXI4-Lite bus
`define REG_CMD          8'h00
`define REG_ADDR         8'h04
`define REG_MASK         8'h08
`define REG_CONFIG       8'h0C
`define REG_STATUS       8'h10
// ==========================================================
// Command codes, CMD[2:0]
`define CMD_MWT          3'h0
`define CMD_SWT          3'h1
`define CMD_STOP         3'h2
`define CMD_RRESET       3'h3
// ==========================================================
// Fields
`define ADDR_ROW_MSB     8
`define ADDR_COL_LSB     16
`define ADDR_COL_MSB     24
`define CFG_CBR_INIT     0
`define CFG_NEW_MASK     1
`define CFG_WE_LOW       2
`define CFG_WE_HIGH      3
`define CFG_RESET        32'h0000000C
`define ST_BUSY          0
`define ST_INIT_DONE     1
`define ST_HALF          2
`define ST_STOP_MODE     3
`define ST_INPUT_MODE    4
`define ST_REFUSED       5
`define ST_SETTLED       6
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
// ==========================================================
// Timing, in ns or cycles, clock rate and init cycle counts
`define CLK_MHZ          250
`define PAUSE_NS         200000
`define PAUSE_CYC        50000
`define T_SETUP_NS       10
`define T_RCD_NS         20
`define T_RAS_NS         80
`define T_RP_NS          60
`define T_SETTLE_NS      20
`define T_SCLK_HALF_NS   12
`define INIT_DUMMIES     4'h8
`define INIT_SCLK_EDGES  5'h10
`endif

// ==== vram_host.v ====
// Notes on behaviour
// - Start split write only after the settle delay since the half indicator changed.
// - A masked full write transfer must come before any split write transfer.
// - After power up hold row strobe and transfer enable high for 200 us.
// - Then at least 8 dummy row strobe and 8 serial clock cycles.
// - Transfer enable stays high throughout initialization.
// - With the internal refresh counter, use 8 column-before-row refreshes instead.
// - After initialization run a register reset cycle before valid operations.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "vram_host_regs.vh"
`default_nettype none
module vram_host #(
    parameter [15:0] PAUSE_CYCLES = `PAUSE_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         ras_n,
    output reg         cas_n,
    output reg         low_byte_write_enable_n,
    output reg         high_byte_write_enable_n,
    output reg         transfer_output_enable_n,
    output reg         special_function_input,
    output reg         serial_clock,
    output reg  [8:0]  address,
    output reg  [15:0] dq_out,
    output reg         dq_oe,
    input  wire        active_half_indicator
);
// ==========================================================
// Helpers
function [15:0] ns_to_cyc;
    input [31:0] ns;
    reg   [31:0] c;
    begin
        c = (ns * `CLK_MHZ + 32'd999) / 32'd1000;
        ns_to_cyc = (c == 32'd0) ? 16'd1 : c[15:0];
    end
endfunction
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
                merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    end
endfunction
localparam [15:0] C_SETUP  = ns_to_cyc(`T_SETUP_NS);
localparam [15:0] C_RCD    = ns_to_cyc(`T_RCD_NS);
localparam [15:0] C_RAS    = ns_to_cyc(`T_RAS_NS);
localparam [15:0] C_RP     = ns_to_cyc(`T_RP_NS);
localparam [15:0] C_SETTLE = ns_to_cyc(`T_SETTLE_NS);
localparam [15:0] C_SCLK   = ns_to_cyc(`T_SCLK_HALF_NS);
localparam [2:0] OP_MWT = 3'h0, OP_SWT = 3'h1, OP_STOP = 3'h2, OP_RRESET = 3'h3,
                 OP_DUMMY = 3'h4, OP_CBR = 3'h5;
localparam [6:0] S_PAUSE = 7'h01, S_SETUP = 7'h02, S_ROW = 7'h04, S_PRE = 7'h08,
                 S_SCLK = 7'h10, S_IDLE = 7'h20, S_SETTLE = 7'h40;
// ==========================================================
// AXI4-Lite slave
reg        aw_got;
reg        w_got;
reg [7:0]  wr_addr;
reg [31:0] wr_data;
reg [3:0]  wr_strb;
reg [31:0] addr_reg;
reg [31:0] mask_reg;
reg [31:0] cfg_reg;
wire [31:0] status;
wire       do_write = aw_got && w_got && !s_axi_bvalid;
wire       cmd_wr   = do_write && (wr_addr == `REG_CMD) && wr_strb[0];
wire       wr_map   = (wr_addr == `REG_CMD) || (wr_addr == `REG_ADDR) ||
                      (wr_addr == `REG_MASK) || (wr_addr == `REG_CONFIG);
assign s_axi_awready = !aw_got && !s_axi_bvalid;
assign s_axi_wready  = !w_got && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        wr_addr      <= 8'h00;
        wr_data      <= 32'h00000000;
        wr_strb      <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `RESP_OKAY;
        addr_reg     <= 32'h00000000;
        mask_reg     <= 32'h00000000;
        cfg_reg      <= `CFG_RESET;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got   <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_addr == `REG_ADDR)
                addr_reg <= merge(addr_reg, wr_data, wr_strb);
            if (wr_addr == `REG_MASK)
                mask_reg <= merge(mask_reg, wr_data, wr_strb);
            if (wr_addr == `REG_CONFIG)
                cfg_reg <= merge(cfg_reg, wr_data, wr_strb);
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
            `REG_ADDR:   s_axi_rdata <= addr_reg;
            `REG_MASK:   s_axi_rdata <= mask_reg;
            `REG_CONFIG: s_axi_rdata <= cfg_reg;
            `REG_STATUS: s_axi_rdata <= status;
            `REG_CMD:    s_axi_rdata <= 32'h00000000;
            default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end
// ==========================================================
// Half indicator synchroniser and settle timer
reg        ahi_s1;
reg        ahi_s2;
reg        ahi_s3;
reg        half;
reg [15:0] settle_cnt;
wire       settle_done = (settle_cnt == C_SETTLE);
// A change still in ahi_s2 or ahi_s3 must block a split as well
wire       settled     = settle_done && (ahi_s2 == half) && (ahi_s3 == half);
always @(posedge aclk) begin
    if (!aresetn) begin
        ahi_s1     <= 1'b0;
        ahi_s2     <= 1'b0;
        ahi_s3     <= 1'b0;
        half       <= 1'b0;
        settle_cnt <= 16'd0;
    end else begin
        ahi_s1 <= active_half_indicator;
        ahi_s2 <= ahi_s1;
        ahi_s3 <= ahi_s2;
        if (ahi_s2 == ahi_s3 && ahi_s3 != half) begin
            half       <= ahi_s3;
            settle_cnt <= 16'd0;
        end else if (!settle_done) begin
            settle_cnt <= settle_cnt + 16'd1;
        end
    end
end
// ==========================================================
// Strobe sequencer
reg [6:0]  state;
reg [15:0] cnt;
reg [2:0]  op;
reg [3:0]  left;
reg [4:0]  sclk_edges;
reg        init_done;
reg        stop_mode;
reg        input_mode;
reg        refused;
wire       is_xfer = (op == OP_MWT) || (op == OP_SWT);
wire       is_cbr  = (op == OP_STOP) || (op == OP_RRESET) || (op == OP_CBR);
wire       we_sel  = (op == OP_MWT) || (op == OP_SWT) || (op == OP_STOP);
assign status = {25'h0, settled, refused, input_mode, stop_mode, half, init_done,
                 (state != S_IDLE)};
always @(posedge aclk) begin
    if (!aresetn) begin
        state                    <= S_PAUSE;
        cnt                      <= 16'd0;
        op                       <= OP_DUMMY;
        left                     <= `INIT_DUMMIES;
        sclk_edges               <= 5'd0;
        init_done                <= 1'b0;
        stop_mode                <= 1'b0;
        input_mode               <= 1'b0;
        refused                  <= 1'b0;
        ras_n                    <= 1'b1;
        cas_n                    <= 1'b1;
        low_byte_write_enable_n  <= 1'b1;
        high_byte_write_enable_n <= 1'b1;
        transfer_output_enable_n <= 1'b1;
        special_function_input   <= 1'b0;
        serial_clock             <= 1'b0;
        address                  <= 9'h000;
        dq_out                   <= 16'h0000;
        dq_oe                    <= 1'b0;
    end else begin
        if (cmd_wr && state != S_IDLE)
            refused <= 1'b1;
        case (state)
            S_PAUSE: begin
                cnt <= cnt + 16'd1;
                if (cnt == PAUSE_CYCLES - 16'd1) begin
                    cnt   <= 16'd0;
                    op    <= cfg_reg[`CFG_CBR_INIT] ? OP_CBR : OP_DUMMY;
                    state <= S_SETUP;
                end
            end
            S_SETUP: begin
                cnt                      <= cnt + 16'd1;
                address                  <= addr_reg[`ADDR_ROW_MSB:0];
                special_function_input   <= (op == OP_SWT) || (op == OP_STOP);
                transfer_output_enable_n <= !is_xfer;
                low_byte_write_enable_n  <= !(we_sel && cfg_reg[`CFG_WE_LOW]);
                high_byte_write_enable_n <= !(we_sel && cfg_reg[`CFG_WE_HIGH]);
                dq_out                   <= mask_reg[15:0];
                dq_oe                    <= is_xfer && cfg_reg[`CFG_NEW_MASK];
                if (is_cbr)
                    cas_n <= 1'b0;
                if (cnt == C_SETUP) begin
                    ras_n <= 1'b0;
                    cnt   <= 16'd0;
                    state <= S_ROW;
                end
            end
            S_ROW: begin
                cnt   <= cnt + 16'd1;
                dq_oe <= 1'b0;
                if (cnt == C_RCD && is_xfer) begin
                    address <= addr_reg[`ADDR_COL_MSB:`ADDR_COL_LSB];
                    cas_n   <= 1'b0;
                end
                if (cnt == C_RAS) begin
                    ras_n                    <= 1'b1;
                    cas_n                    <= 1'b1;
                    transfer_output_enable_n <= 1'b1;
                    low_byte_write_enable_n  <= 1'b1;
                    high_byte_write_enable_n <= 1'b1;
                    special_function_input   <= 1'b0;
                    cnt                      <= 16'd0;
                    state                    <= S_PRE;
                    if (op == OP_MWT)
                        input_mode <= 1'b1;
                    if (op == OP_STOP)
                        stop_mode <= 1'b1;
                    if (op == OP_RRESET)
                        stop_mode <= 1'b0;
                end
            end
            S_PRE: begin
                cnt <= cnt + 16'd1;
                if (cnt == C_RP) begin
                    cnt <= 16'd0;
                    if (op == OP_DUMMY || op == OP_CBR) begin
                        left  <= left - 4'd1;
                        state <= (left == 4'd1) ? S_SCLK : S_SETUP;
                    end else begin
                        init_done <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
            end
            S_SCLK: begin
                cnt <= cnt + 16'd1;
                if (cnt == C_SCLK) begin
                    cnt          <= 16'd0;
                    serial_clock <= !serial_clock;
                    sclk_edges   <= sclk_edges + 5'd1;
                    if (sclk_edges == `INIT_SCLK_EDGES - 5'd1) begin
                        op    <= OP_RRESET;
                        state <= S_SETUP;
                    end
                end
            end
            S_IDLE: begin
                if (cmd_wr) begin
                    refused <= 1'b0;
                    cnt     <= 16'd0;
                    op      <= wr_data[2:0];
                    if (wr_data[2:0] == `CMD_SWT && !input_mode) begin
                        refused <= 1'b1;
                    end else if (wr_data[2:0] == `CMD_SWT) begin
                        state <= S_SETTLE;
                    end else if (wr_data[2:0] == `CMD_MWT || wr_data[2:0] == `CMD_STOP ||
                                 wr_data[2:0] == `CMD_RRESET) begin
                        state <= S_SETUP;
                    end else begin
                        refused <= 1'b1;
                    end
                end
            end
            S_SETTLE: begin
                if (settled)
                    state <= S_SETUP;
            end
            default: state <= S_IDLE;
        endcase
    end
end
endmodule // vram_host
`default_nettype wire

// ==== vram_dev_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Device side: decodes each strobe cycle at the row strobe fall
module vram_dev_model (
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_lo_n,
    input  wire logic        we_hi_n,
    input  wire logic        xfer_n,
    input  wire logic        sfi,
    input  wire logic        sclk,
    input  wire logic [8:0]  a,
    input  wire logic [15:0] dq,
    input  wire logic        dq_oe,
    input  wire logic        flip,
    output wire logic        half
);
    int          n_dummy = 0, n_mwt = 0, n_swt = 0, n_stop = 0, n_rst = 0, n_sclk = 0;
    int          stops = 0;
    logic        stop_mode = 1'b0, input_mode = 1'b0, persist = 1'b0, mask_new = 1'b0;
    logic [8:0]  row = 9'h000, col = 9'h000;
    logic [3:0]  field = 4'h0;
    logic [15:0] mask = 16'h0000;
    wire logic   we_any = !we_lo_n || !we_hi_n;
    // Serial traffic is owned by the bench, so it decides when a half runs out
    assign half = flip;
    always @(posedge sclk) n_sclk++;
    always @(negedge cas_n) if (!ras_n) col = a;
    always @(negedge ras_n) begin
        if (cas_n && !xfer_n && we_any) begin
            row = a;
            mask_new = dq_oe;
            if (dq_oe) mask = dq;
            persist = !dq_oe;
            if (!sfi) begin
                n_mwt++;
                input_mode = 1'b1;
            end else if (input_mode) n_swt++;
        end else if (cas_n && xfer_n) begin
            if (n_rst == 0) n_dummy++;
        end else if (!cas_n && sfi && we_any) begin
            field = a[7:4];
            stops = !a[4] ? 16 : !a[5] ? 8 : !a[6] ? 4 : !a[7] ? 2 : 1;
            stop_mode = 1'b1;
            n_stop++;
        end else if (!cas_n && !sfi && !we_any) begin
            stop_mode = 1'b0;
            persist = 1'b0;
            n_rst++;
        end
    end
endmodule // vram_dev_model
`default_nettype wire

// ==== vram_host_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module vram_host_chk #(
    parameter [15:0] PAUSE_CYCLES = 16'hC350
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic low_byte_write_enable_n,
    input wire logic high_byte_write_enable_n,
    input wire logic transfer_output_enable_n,
    input wire logic special_function_input,
    input wire logic serial_clock,
    input wire logic active_half_indicator
);
    logic [15:0] pause_cnt;
    logic [3:0]  sclk_cnt, fall_cnt, quiet;
    logic        sclk_d, ras_d, half_d, mwt_seen, rr_seen;
    wire logic   lo_n = low_byte_write_enable_n;
    wire logic   hi_n = high_byte_write_enable_n;
    wire logic   tn = transfer_output_enable_n;
    wire logic   sf = special_function_input;
    wire logic   fall = ras_d && !ras_n;
    // ==========================================
    // History of the pins since reset
    always @(posedge aclk) begin
        sclk_d <= serial_clock;
        ras_d <= ras_n;
        half_d <= active_half_indicator;
        if (!aresetn) begin
            pause_cnt <= 16'h0000;
            sclk_cnt <= 4'h0;
            fall_cnt <= 4'h0;
            quiet <= 4'hF;
            mwt_seen <= 1'b0;
            rr_seen <= 1'b0;
        end else begin
            if (pause_cnt != 16'hFFFF) pause_cnt <= pause_cnt + 16'h0001;
            if (serial_clock && !sclk_d && sclk_cnt != 4'hF) sclk_cnt <= sclk_cnt + 4'h1;
            if (fall && fall_cnt != 4'hF) fall_cnt <= fall_cnt + 4'h1;
            if (active_half_indicator != half_d) quiet <= 4'h0;
            else if (quiet != 4'hF) quiet <= quiet + 4'h1;
            if (fall && !tn && cas_n && !sf) mwt_seen <= 1'b1;
            if (fall && !cas_n && !sf && lo_n && hi_n) rr_seen <= 1'b1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_fall;
        $fell(ras_n);
    endsequence
    sequence s_xfer;
        s_fall ##0 (!tn && cas_n);
    endsequence
    sequence s_split;
        s_xfer ##0 sf;
    endsequence
    a_pause_hold: assert property (pause_cnt < PAUSE_CYCLES |-> ras_n && tn)
        else $error("strobe moved during power-up pause");
    a_init_trg: assert property (sclk_cnt < 4'd8 |-> tn)
        else $error("transfer enable low during init");
    a_init_first: assert property (s_xfer |-> fall_cnt >= 4'd9 && sclk_cnt >= 4'd8 && rr_seen)
        else $error("transfer before init finished");
    a_split_order: assert property (s_split |-> mwt_seen)
        else $error("split write before masked write transfer");
    a_split_settle: assert property (s_split |-> quiet >= 4'd5)
        else $error("split write too soon after half change");
    a_split_code: assert property (s_split |-> !lo_n || !hi_n)
        else $error("split write without byte enable");
    a_stop_code: assert property (s_fall ##0 (!cas_n && sf) |-> (!lo_n || !hi_n) && tn)
        else $error("stop set code wrong");
    a_reset_code: assert property (s_fall ##0 (!cas_n && !sf) |-> lo_n && hi_n && tn)
        else $error("register reset code wrong");
endmodule // vram_host_chk
bind vram_host vram_host_chk #(.PAUSE_CYCLES(PAUSE_CYCLES)) chk_u (
    .aclk, .aresetn, .ras_n, .cas_n, .low_byte_write_enable_n, .high_byte_write_enable_n,
    .transfer_output_enable_n, .special_function_input, .serial_clock, .active_half_indicator);
`default_nettype wire

// ==== vram_host_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "vram_host_regs.vh"
module vram_host_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, half_flip = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   ras_n, cas_n, low_byte_write_enable_n, high_byte_write_enable_n, dq_oe;
    wire logic   transfer_output_enable_n, special_function_input, serial_clock;
    wire logic   active_half_indicator;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [8:0]  address;
    wire logic [15:0] dq_out;
    logic [3:0]  stop_base [5] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0};
    logic [3:0]  stop_dc [5] = '{4'h0, 4'h0, 4'h8, 4'hC, 4'hE};
    int          stop_num [5] = '{1, 2, 4, 8, 16};
    int          bad_count = 0, samples_checked = 0;
    always #2 aclk = ~aclk;
    vram_host #(.PAUSE_CYCLES(16'd20)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ras_n, .cas_n,
        .low_byte_write_enable_n, .high_byte_write_enable_n, .transfer_output_enable_n,
        .special_function_input, .serial_clock, .address, .dq_out, .dq_oe, .active_half_indicator);
    vram_dev_model dev_u (.ras_n, .cas_n, .we_lo_n(low_byte_write_enable_n),
        .we_hi_n(high_byte_write_enable_n), .xfer_n(transfer_output_enable_n),
        .sfi(special_function_input), .sclk(serial_clock), .a(address), .dq(dq_out), .dq_oe,
        .flip(half_flip), .half(active_half_indicator));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic poll(input int b, input logic v);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        do begin
            rd(`REG_STATUS, d, r);
            n++;
        end while (d[b] !== v && n < 500);
        if (n == 500) chk("status_wait", v, d[b]);
    endtask
    // Flipping the half with the command forces the controller to honour the settle wait
    task automatic cmd(input logic [2:0] c, input logic f);
        logic [1:0] r;
        if (f) half_flip <= ~half_flip;
        wr(`REG_CMD, {29'h0, c}, r);
        poll(`ST_BUSY, 1'b0);
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(4 * 40000);
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        results;
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [8:0]  ad;
        logic [15:0] mask;
        int          ex_swt;
        int          n0;
        ex_swt = 0;
        void'($urandom(32'hD50D));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REG_CONFIG, d, r);
        chk("config_reset", `CFG_RESET, d);
        rd(8'h14, d, r);
        chk("unmapped_rresp", `RESP_SLVERR, r);
        chk("unmapped_rdata", 32'h0, d);
        wr(8'h18, $urandom, r);
        chk("unmapped_bresp", `RESP_SLVERR, r);
        poll(`ST_INIT_DONE, 1'b1);
        chk("dummy_ras", `INIT_DUMMIES, dev_u.n_dummy);
        chk("serial_cycles", `INIT_SCLK_EDGES >> 1, dev_u.n_sclk);
        chk("init_reg_reset", 1, dev_u.n_rst);
        $display("test init done");
        cmd(`CMD_SWT, 1'b0);
        rd(`REG_STATUS, d, r);
        chk("early_split_refused", 1, d[`ST_REFUSED]);
        chk("early_split_count", 0, dev_u.n_swt);
        $display("test early split done");
        for (int i = 0; i < 3; i++) begin
            mask = $urandom;
            ad = $urandom;
            wr(`REG_CONFIG, (i == 2) ? 32'h8 : 32'h6, r);
            wr(`REG_MASK, {16'h0, mask}, r);
            wr(`REG_ADDR, {7'h0, ad, 7'h0, ad}, r);
            cmd((i == 0) ? `CMD_MWT : `CMD_SWT, i != 0);
            if (i != 0) ex_swt++;
            chk("split_count", ex_swt, dev_u.n_swt);
            chk("row", ad, dev_u.row);
            chk("column", ad, dev_u.col);
            chk("mask_new", i != 2, dev_u.mask_new);
            if (i != 2) chk("mask", mask, dev_u.mask);
            rd(`REG_STATUS, d, r);
            chk("half", half_flip, d[`ST_HALF]);
            chk("input_mode", 1, d[`ST_INPUT_MODE]);
        end
        $display("test transfers done");
        for (int i = 0; i < 5; i++) begin
            ad = $urandom;
            ad[7:4] = stop_base[i] | (ad[7:4] & stop_dc[i]);
            wr(`REG_ADDR, {23'h0, ad}, r);
            cmd(`CMD_STOP, 1'b0);
            chk("stop_field", ad[7:4], dev_u.field);
            chk("stop_count", stop_num[i], dev_u.stops);
            rd(`REG_STATUS, d, r);
            chk("stop_mode", 1, d[`ST_STOP_MODE] & dev_u.stop_mode);
        end
        $display("test stop set done");
        cmd(`CMD_RRESET, 1'b0);
        chk("stop_cleared", 0, dev_u.stop_mode);
        chk("persist_cleared", 0, dev_u.persist);
        rd(`REG_STATUS, d, r);
        chk("stop_mode_status", 0, d[`ST_STOP_MODE]);
        cmd(3'h5, 1'b0);
        rd(`REG_STATUS, d, r);
        chk("bad_code_refused", 1, d[`ST_REFUSED]);
        $display("test register reset done");
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        n0 = dev_u.n_rst;
        wr(`REG_CONFIG, 32'hD, r);
        poll(`ST_INIT_DONE, 1'b1);
        chk("cbr_refresh", `INIT_DUMMIES + 1, dev_u.n_rst - n0);
        chk("dummy_kept", `INIT_DUMMIES, dev_u.n_dummy);
        chk("serial_cycles_2", `INIT_SCLK_EDGES, dev_u.n_sclk);
        rd(`REG_STATUS, d, r);
        chk("input_mode_reset", 0, d[`ST_INPUT_MODE]);
        $display("test second reset done");
        results;
    end
endmodule // vram_host_tb
`default_nettype wire
